/* File: design/capseq_pkg.sv */
/*
  Package for the triggered capture sequencer: timing counts, state
  encoding and the packed carriers shared by the sequencer files.
  Assumes a single 100 MHz core clock.
*/
package capseq_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ABORT_TIME_US = 7000;
  localparam int unsigned ABORT_CYCLES = (CLK_HZ / 1_000_000) * ABORT_TIME_US;
  localparam int unsigned FPS_DEFAULT = 30;
  localparam int unsigned FRAME_CYCLES_DEFAULT = CLK_HZ / FPS_DEFAULT;
  localparam int CNT_W = 32;
  localparam int NUM_PORTS = 4;
  localparam int NUM_STREAMS = 3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_FREE  = 2'b00,
    ST_ABORT = 2'b01,
    ST_TRIG  = 2'b10
  } seq_state_t;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [NUM_PORTS-1:0] trig_en;
    logic [NUM_PORTS-1:0] invert;
  } port_cfg_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic triggered;
  } cap_cmd_t;

  typedef struct packed {
    logic [NUM_STREAMS-1:0] keep;
    logic [NUM_STREAMS-1:0] drop;
    logic triggered;
  } stream_ctl_t;

endpackage

/* File: design/trig_detect.sv */
/*
  Trigger edge detector: turns the configured input ports into a single
  trigger pulse on the chosen transition of any enabled port.
  Assumes the port levels are already synchronous to i_clk.
*/
`timescale 1ns/1ps
module trig_detect (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // ports
  input wire logic [capseq_pkg::NUM_PORTS-1:0] i_port,
  input wire capseq_pkg::port_cfg_t i_cfg,
  // trigger
  output logic o_trig
);

  logic [capseq_pkg::NUM_PORTS-1:0] prev_r;
  logic [capseq_pkg::NUM_PORTS-1:0] act;
  logic [capseq_pkg::NUM_PORTS-1:0] act_prev;

  // ****************************************************************
  // edge detection
  // ****************************************************************
  assign act = i_port ^ i_cfg.invert;
  assign act_prev = prev_r ^ i_cfg.invert;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prev_r <= i_cfg.invert;
    end else begin
      prev_r <= i_port;
    end
  end

  // inactive to active after inversion, any enabled port
  assign o_trig = |(act & ~act_prev & i_cfg.trig_en);

endmodule

/* File: design/triggered_capture_sequencer.sv */
/*
  Triggered capture sequencer: internal frame timer, trigger abort
  interval, triggered capture and per-stream keep/drop of images.
  Assumes the sensor reports o_start-launched captures as finished on
  i_readout_done and that the frame period input is held stable.
*/
// Function
// - internal timer starts exposure each frame period
// - trigger immediately aborts captures in progress
// - triggered exposure starts exactly 7 ms later
// - capture spans exposure start to readout done
// - completed triggered image is output
// - internal timing resumes one period after abort
// - aborted internal captures are discarded
// - zero to two images dropped per trigger
// - drops apply to every enabled stream
// - triggered image goes to all enabled streams
// - trigger is configured transition, inversion aware
// - any configured trigger port may trigger
`timescale 1ns/1ps
module triggered_capture_sequencer #(
  // abort length in core cycles
  parameter int unsigned ABORT_LEN = capseq_pkg::ABORT_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // configuration
  input wire logic [capseq_pkg::CNT_W-1:0] i_frame_cycles,
  input wire capseq_pkg::port_cfg_t i_port_cfg,
  input wire logic [capseq_pkg::NUM_STREAMS-1:0] i_stream_en,
  // trigger ports
  input wire logic [capseq_pkg::NUM_PORTS-1:0] i_port,
  // sensor side
  input wire logic i_readout_done,
  output capseq_pkg::cap_cmd_t o_cmd,
  // stream encoders
  output capseq_pkg::stream_ctl_t o_stream,
  // status
  output logic o_busy,
  output logic [1:0] o_drop_count
);

  capseq_pkg::seq_state_t state_r;
  logic trig;
  logic [capseq_pkg::CNT_W-1:0] frame_cnt_r;
  logic [capseq_pkg::CNT_W-1:0] abort_cnt_r;
  logic [1:0] in_flight_r;
  logic trig_pending_r;
  logic frame_tick;
  logic abort_done;
  logic start_now;
  capseq_pkg::cap_cmd_t cmd_r;
  capseq_pkg::stream_ctl_t stream_r;
  logic [1:0] drop_r;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [capseq_pkg::CNT_W-1:0] period_or_one(
    input logic [capseq_pkg::CNT_W-1:0] p);
    period_or_one = (p == capseq_pkg::CNT_RST) ? 32'h0000_0001 : p;
  endfunction

  function automatic logic [1:0] sat_inc(input logic [1:0] v);
    sat_inc = (v == 2'h3) ? v : v + 2'h1;
  endfunction

  // ****************************************************************
  // trigger detection
  // ****************************************************************
  trig_detect u_trig (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_port(i_port),
    .i_cfg(i_port_cfg),
    .o_trig(trig)
  );

  // ****************************************************************
  // state machine
  // ****************************************************************
  assign abort_done = (state_r == capseq_pkg::ST_ABORT) &&
                      (abort_cnt_r == 32'h0000_0001);
  // also ticks in the triggered period so internal timing resumes on time
  assign frame_tick = (state_r != capseq_pkg::ST_ABORT) &&
                      (frame_cnt_r == 32'h0000_0001);
  // a trigger in the same cycle cancels any start
  assign start_now = (frame_tick | abort_done) && !trig;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_r <= capseq_pkg::ST_FREE;
    end else begin
      case (state_r)
        capseq_pkg::ST_FREE: begin
          if (trig) begin
            state_r <= capseq_pkg::ST_ABORT;
          end
        end
        capseq_pkg::ST_ABORT: begin
          if (trig) begin
            state_r <= capseq_pkg::ST_ABORT;
          end else if (abort_done) begin
            state_r <= capseq_pkg::ST_TRIG;
          end
        end
        capseq_pkg::ST_TRIG: begin
          if (trig) begin
            state_r <= capseq_pkg::ST_ABORT;
          end else if (frame_cnt_r == 32'h0000_0001) begin
            state_r <= capseq_pkg::ST_FREE;
          end
        end
        default: begin
          state_r <= capseq_pkg::ST_FREE;
        end
      endcase
    end
  end

  // ****************************************************************
  // abort down-counter
  // ****************************************************************
  // reloads on every trigger, so a retrigger restarts the abort
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      abort_cnt_r <= capseq_pkg::CNT_RST;
    end else if (trig) begin
      abort_cnt_r <= ABORT_LEN;
    end else if (state_r == capseq_pkg::ST_ABORT) begin
      abort_cnt_r <= abort_cnt_r - 32'h0000_0001;
    end
  end

  // ****************************************************************
  // frame timer
  // ****************************************************************
  // frozen while aborting, reloaded when the abort ends
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      frame_cnt_r <= period_or_one(i_frame_cycles);
    end else if (abort_done) begin
      frame_cnt_r <= period_or_one(i_frame_cycles);
    end else if (state_r == capseq_pkg::ST_ABORT) begin
      frame_cnt_r <= frame_cnt_r;
    end else if (frame_cnt_r == 32'h0000_0001) begin
      frame_cnt_r <= period_or_one(i_frame_cycles);
    end else begin
      frame_cnt_r <= frame_cnt_r - 32'h0000_0001;
    end
  end

  // ****************************************************************
  // capture tracking
  // ****************************************************************
  // captures in flight between exposure start and readout done
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      in_flight_r <= 2'h0;
    end else if (trig) begin
      in_flight_r <= 2'h0;
    end else begin
      case ({frame_tick | abort_done, i_readout_done && in_flight_r != 2'h0})
        2'b10: in_flight_r <= sat_inc(in_flight_r);
        2'b01: in_flight_r <= in_flight_r - 2'h1;
        default: in_flight_r <= in_flight_r;
      endcase
    end
  end

  // triggered image is oldest in flight after an abort
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      trig_pending_r <= 1'b0;
    end else if (trig) begin
      trig_pending_r <= 1'b0;
    end else if (abort_done) begin
      trig_pending_r <= 1'b1;
    end else if (i_readout_done && in_flight_r != 2'h0) begin
      trig_pending_r <= 1'b0;
    end
  end

  // ****************************************************************
  // sensor commands
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cmd_r <= '0;
    end else begin
      cmd_r.start <= start_now;
      cmd_r.abort <= trig;
      cmd_r.triggered <= abort_done && !trig;
    end
  end

  // ****************************************************************
  // stream keep and drop
  // ****************************************************************
  // a trigger wins over a readout in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      stream_r <= '0;
      drop_r <= 2'h0;
    end else begin
      stream_r.keep <= (i_readout_done && in_flight_r != 2'h0 && !trig) ?
                       i_stream_en : '0;
      stream_r.triggered <= i_readout_done && trig_pending_r && !trig;
      stream_r.drop <= (trig && in_flight_r != 2'h0) ? i_stream_en : '0;
      if (trig) begin
        drop_r <= (in_flight_r > 2'h2) ? 2'h2 : in_flight_r;
      end
    end
  end

  assign o_cmd = cmd_r;
  assign o_stream = stream_r;
  assign o_busy = (state_r != capseq_pkg::ST_FREE);
  assign o_drop_count = drop_r;

endmodule

/* File: test/trig_src.sv */
/*
  Trigger source model: drives the four trigger port levels.
  Assumes ports 1 and 2 are trigger ports, port 2 inverted.
*/
`timescale 1ns/1ps
module trig_src (
  // clock
  input wire logic i_clk,
  // ports
  output logic [capseq_pkg::NUM_PORTS-1:0] o_port
);
  // ****************************************************************
  // levels
  // ****************************************************************
  initial begin
    o_port = 4'h4;
  end
  task toggle(input int p);
    @(negedge i_clk);
    o_port[p] = ~o_port[p];
  endtask
endmodule

/* File: test/capseq_sva.sv */
/*
  Checker for the sequencer ports.
  Assumes a frame period held stable and bound to the top module.
*/
`timescale 1ns/1ps
module capseq_sva #(
  parameter int unsigned ABORT_LEN = capseq_pkg::ABORT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [capseq_pkg::CNT_W-1:0] i_frame_cycles,
  input wire capseq_pkg::port_cfg_t i_port_cfg,
  input wire logic [capseq_pkg::NUM_STREAMS-1:0] i_stream_en,
  input wire logic [capseq_pkg::NUM_PORTS-1:0] i_port,
  input wire logic i_readout_done,
  input wire capseq_pkg::cap_cmd_t o_cmd,
  input wire capseq_pkg::stream_ctl_t o_stream,
  input wire logic o_busy,
  input wire logic [1:0] o_drop_count
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  logic [3:0] prev_r;
  logic [31:0] ac_r;
  logic [31:0] sc_r;
  logic seen_r;
  logic inab_r;
  wire logic [3:0] act = i_port ^ i_port_cfg.invert;
  wire logic rise = |(act & ~prev_r & i_port_cfg.trig_en);
  always_ff @(posedge i_clk) begin
    prev_r <= i_rst_b ? act : 4'h0;
  end
  always_ff @(posedge i_clk) begin
    ac_r <= (!i_rst_b || o_cmd.abort) ? 32'h0 : ac_r + 32'h1;
    sc_r <= (!i_rst_b || o_cmd.start) ? 32'h0 : sc_r + 32'h1;
    seen_r <= i_rst_b && (seen_r || o_cmd.start);
    inab_r <= i_rst_b && (o_cmd.abort || (inab_r && !o_cmd.triggered));
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_PERIOD: assert property (o_cmd.start && !o_cmd.triggered && seen_r
    |-> sc_r == i_frame_cycles - 32'h1) else $error("internal start spacing wrong");
  AST_ABORT: assert property (rise |-> ##1 o_cmd.abort)
    else $error("trigger not aborting");
  AST_ABORT_TIME: assert property (o_cmd.triggered
    |-> ac_r == ABORT_LEN - 1) else $error("abort length wrong");
  AST_NO_START_ON_ABORT: assert property (o_cmd.abort |-> !o_cmd.start)
    else $error("start issued with abort");
  AST_TRIG_START: assert property (o_cmd.triggered |-> o_cmd.start)
    else $error("triggered without start");
  AST_QUIET: assert property (inab_r && !o_cmd.triggered |-> !o_cmd.start)
    else $error("start during abort");
  AST_BUSY: assert property ($rose(o_busy) |-> o_cmd.abort)
    else $error("busy without abort");
  AST_DROP: assert property (|o_stream.drop
    |-> o_cmd.abort && o_stream.drop == i_stream_en) else $error("drop mask wrong");
  AST_KEEP: assert property (|o_stream.keep
    |-> $past(i_readout_done) && o_stream.keep == i_stream_en) else $error("keep wrong");
  AST_DROP_MAX: assert property (o_drop_count <= 2'h2)
    else $error("drop count too big");
  C_TRIG: cover property (o_cmd.triggered);
  C_DROP: cover property (|o_stream.drop);
  C_TKEEP: cover property (o_stream.triggered);
endmodule
bind triggered_capture_sequencer capseq_sva #(.ABORT_LEN(ABORT_LEN)) u_capseq_sva (.*);

/* File: test/triggered_capture_sequencer_test.sv */
/*
  Testbench: free running starts, trigger abort and triggered image.
  Assumes a 100 MHz clock; frame period shortened to 40 cycles and
  abort interval shortened to ABORT_TB cycles to keep the run short.
*/
`timescale 1ns/1ps
module triggered_capture_sequencer_test;
  logic i_clk;
  logic i_rst_b;
  logic rd;
  logic [3:0] port;
  capseq_pkg::port_cfg_t cfg;
  logic [2:0] en;
  capseq_pkg::cap_cmd_t cmd;
  capseq_pkg::stream_ctl_t st;
  logic busy;
  logic [1:0] dcnt;
  int err_count;
  int check_count;
  int n;
  localparam int unsigned ABORT_TB = 500;
  trig_src u_trig_src (.i_clk(i_clk), .o_port(port));
  triggered_capture_sequencer #(.ABORT_LEN(ABORT_TB)) u_triggered_capture_sequencer (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_frame_cycles(32'h28), .i_port_cfg(cfg), .i_stream_en(en),
    .i_port(port), .i_readout_done(rd), .o_cmd(cmd), .o_stream(st), .o_busy(busy),
    .o_drop_count(dcnt));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task wait_ev(input int abrt, input int lim, output int cyc);
    cyc = 0;
    do begin
      @(negedge i_clk);
      cyc++;
    end while ((abrt ? cmd.abort : cmd.start) !== 1'b1 && cyc < lim);
  endtask
  task readout;
    rd = 1'b1;
    @(negedge i_clk);
    rd = 1'b0;
  endtask
  task sc_free;
    wait_ev(0, 100, n);
    wait_ev(0, 100, n);
    chk(n, 32'd40);
    readout();
    chk(st.keep, en);
    // port 0 is not a trigger port: no abort may follow
    u_trig_src.toggle(0);
    wait_ev(1, 5, n);
    chk(n < 5, 0);
  endtask
  task sc_trig;
    wait_ev(0, 100, n);
    u_trig_src.toggle(2);
    wait_ev(1, 5, n);
    chk(n < 4, 1);
    chk(st.drop, en);
    chk(busy, 1);
    wait_ev(0, ABORT_TB + 10, n);
    chk(n, ABORT_TB);
    chk(cmd.triggered, 1);
    chk(dcnt, 2);
    readout();
    chk(st.keep, en);
    chk(st.triggered, 1);
    wait_ev(0, 100, n);
    chk(n, 32'd39);
  endtask
  // expected run is under 1000 cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    print_verdict();
  end
  initial begin
    err_count = 0;
    check_count = 0;
    i_rst_b = 1'b0;
    rd = 1'b0;
    en = 3'h5;
    cfg = '{trig_en: 4'h6, invert: 4'h4};
    repeat (12) @(negedge i_clk);
    i_rst_b = 1'b1;
    sc_free();
    sc_trig();
    print_verdict();
  end
endmodule
